// file: logic/cx_pkg.sv
`default_nettype none
package cx_pkg;
    // widths and depths
    localparam int unsigned ADDR_W    = 8;
    localparam int unsigned DATA_W    = 32;
    localparam int unsigned PC_W      = 13;
    localparam int unsigned STK_DEPTH = 8;
    localparam int unsigned SP_W      = 3;
    localparam int unsigned FILE_NUM  = 128;
    localparam int unsigned FADDR_W   = 7;
    localparam int unsigned OP_W      = 3;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFF_CMD    = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_ACCUM  = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_PC     = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_PUSH   = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_FADDR  = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_FDATA  = 8'h18;

    // command word fields
    localparam int unsigned CMD_OP_LSB   = 0;
    localparam int unsigned CMD_DEST_BIT = 3;
    localparam int unsigned CMD_FA_LSB   = 4;
    localparam int unsigned CMD_LIT_LSB  = 16;

    // status word fields
    localparam int unsigned STAT_C_BIT    = 0;
    localparam int unsigned STAT_HC_BIT   = 1;
    localparam int unsigned STAT_Z_BIT    = 2;
    localparam int unsigned STAT_BUSY_BIT = 8;

    // reset values and the stack pointer step
    localparam logic [7:0]      ACCUM_RST = 8'h00;
    localparam logic [PC_W-1:0] PC_RST    = 13'h0000;
    localparam logic [SP_W-1:0] SP_RST    = 3'h0;
    localparam logic [SP_W-1:0] SP_ONE    = 3'h1;

    // cycles taken by a subroutine return
    localparam int unsigned RET_CYCLES = 2;

    // operation codes held in the command word
    typedef enum logic [OP_W-1:0] {
        op_return              = 3'h0,
        rotate_right_carry_op  = 3'h1,
        literal_minus_accum_op = 3'h2,
        file_minus_accum_op    = 3'h3,
        nibble_exchange_op     = 3'h4,
        literal_xor_op         = 3'h5,
        file_xor_op            = 3'h6,
        op_none                = 3'h7
    } cx_op_t;

    // sequencer states
    typedef enum logic [2:0] {
        st_idle = 3'b001,
        st_exec = 3'b010,
        st_ret  = 3'b100
    } cx_state_t;
endpackage
`default_nettype wire

// file: logic/cx_alu.sv
`default_nettype none
module cx_alu (
    // operation and operands
    input  wire logic           i_op_valid,
    input  wire cx_pkg::cx_op_t i_op,
    input  wire logic [7:0]     i_accum,
    input  wire logic [7:0]     i_fval,
    input  wire logic [7:0]     i_literal,
    input  wire logic           i_carry,
    // result and flag updates
    output logic      [7:0]     o_result,
    output logic                o_carry,
    output logic                o_half_carry,
    output logic                o_zero,
    output logic                o_upd_c,
    output logic                o_upd_hc,
    output logic                o_upd_z,
    output logic                o_file_op
);
    logic [7:0] minuend;
    logic [8:0] diff9;
    logic [4:0] nib5;

    // subtract as minuend plus inverted accumulator plus one
    always_comb begin
        minuend = (i_op == cx_pkg::literal_minus_accum_op) ? i_literal : i_fval;
        diff9   = {1'b0, minuend} + {1'b0, ~i_accum} + 9'h001;
        nib5    = {1'b0, minuend[3:0]} + {1'b0, ~i_accum[3:0]} + 5'h01;
    end

    // result and which flags each operation touches
    always_comb begin
        o_result     = i_fval;
        o_carry      = i_carry;
        o_half_carry = nib5[4];              // no borrow out of bit 3 sets it [RQ9]
        o_upd_c      = 1'b0;
        o_upd_hc     = 1'b0;
        o_upd_z      = 1'b0;
        o_file_op    = 1'b0;
        unique case (i_op)
            cx_pkg::rotate_right_carry_op: begin
                o_result  = {i_carry, i_fval[7:1]};  // carry in at msb [RQ2]
                o_carry   = i_fval[0];               // old lsb out to carry [RQ2]
                o_upd_c   = i_op_valid;
                o_file_op = 1'b1;
            end
            cx_pkg::literal_minus_accum_op, cx_pkg::file_minus_accum_op: begin
                o_result  = diff9[7:0];              // [RQ4] [RQ5]
                o_carry   = diff9[8];                // set when no borrow [RQ9]
                o_upd_c   = i_op_valid;
                o_upd_hc  = i_op_valid;
                o_upd_z   = i_op_valid;
                o_file_op = (i_op == cx_pkg::file_minus_accum_op);
            end
            cx_pkg::nibble_exchange_op: begin
                o_result  = {i_fval[3:0], i_fval[7:4]};  // no flag touched [RQ6]
                o_file_op = 1'b1;
            end
            cx_pkg::literal_xor_op: begin
                o_result  = i_accum ^ i_literal;     // zero flag only [RQ7]
                o_upd_z   = i_op_valid;
            end
            cx_pkg::file_xor_op: begin
                o_result  = i_accum ^ i_fval;        // zero flag only [RQ8]
                o_upd_z   = i_op_valid;
                o_file_op = 1'b1;
            end
            default: begin
                o_result = i_accum;
            end
        endcase
        o_zero = (o_result == 8'h00);            // [RQ9]
    end
endmodule
`default_nettype wire

// file: logic/cx_exec.sv
// Contract
// [RQ1] return pops the stack into the program counter, two cycles, flags kept
// [RQ2] rotate right moves carry into msb and the old lsb into carry
// [RQ3] destination bit 0 writes the accumulator, 1 writes the file register back
// [RQ4] literal minus accumulator goes to accumulator, updating carry, half carry, zero
// [RQ5] file minus accumulator goes to the chosen destination, updating three flags
// [RQ6] nibble swap exchanges the halves of the file register, flags unchanged
// [RQ7] literal xor accumulator goes to accumulator, only zero flag updated
// [RQ8] file xor accumulator goes to the chosen destination, only zero updated
// [RQ9] subtraction carry and half carry mean no borrow; zero means result zero
`default_nettype none
module cx_exec (
    // clock and reset
    input  wire logic                         i_core_clk,
    input  wire logic                         i_reset_n,
    // apb slave
    input  wire logic                         i_psel,
    input  wire logic                         i_penable,
    input  wire logic                         i_pwrite,
    input  wire logic [cx_pkg::ADDR_W-1:0]    i_paddr,
    input  wire logic [cx_pkg::DATA_W-1:0]    i_pwdata,
    output logic      [cx_pkg::DATA_W-1:0]    o_prdata,
    output logic                              o_pready,
    output logic                              o_pslverr,
    // core state
    output logic      [cx_pkg::PC_W-1:0]      o_pc,
    output logic                              o_busy
);
    cx_pkg::cx_state_t              state_q, state_d;
    cx_pkg::cx_op_t                 op_q, op_d;
    logic                           dest_q, dest_d;
    logic [cx_pkg::FADDR_W-1:0]     fa_q, fa_d, faddr_q, faddr_d;
    logic [7:0]                     lit_q, lit_d, accum_q, accum_d;
    logic                           c_q, c_d, hc_q, hc_d, z_q, z_d;
    logic [cx_pkg::PC_W-1:0]        pc_q, pc_d;
    logic [cx_pkg::SP_W-1:0]        sp_q, sp_d, sp_dec;
    logic [cx_pkg::DATA_W-1:0]      prdata_q, prdata_d;
    logic [7:0]                     file_mem [cx_pkg::FILE_NUM];
    logic [cx_pkg::PC_W-1:0]        stack_mem [cx_pkg::STK_DEPTH];
    logic                           file_we, stk_we;
    logic [cx_pkg::FADDR_W-1:0]     file_wa;
    logic [7:0]                     file_wd, fval;
    logic [cx_pkg::PC_W-1:0]        stack_top;
    logic [7:0]                     alu_res;
    logic                           alu_c, alu_hc, alu_z;
    logic                           upd_c, upd_hc, upd_z, file_op;
    logic                           busy, wr_fire, mapped, executing;

    // decode helpers and bus handshake
    assign busy      = (state_q != cx_pkg::st_idle);
    assign executing = (state_q == cx_pkg::st_exec);
    assign sp_dec    = sp_q - cx_pkg::SP_ONE;
    assign stack_top = stack_mem[sp_dec];
    assign fval      = file_mem[fa_q];
    assign mapped    = (i_paddr == cx_pkg::OFF_CMD)   || (i_paddr == cx_pkg::OFF_ACCUM) ||
                       (i_paddr == cx_pkg::OFF_STATUS) || (i_paddr == cx_pkg::OFF_PC) ||
                       (i_paddr == cx_pkg::OFF_PUSH)  || (i_paddr == cx_pkg::OFF_FADDR) ||
                       (i_paddr == cx_pkg::OFF_FDATA);
    assign o_pready  = ~(i_pwrite && busy);        // writes wait until the core is idle
    assign o_pslverr = i_psel && i_penable && o_pready && !mapped;
    assign wr_fire   = i_psel && i_penable && i_pwrite && o_pready;
    assign o_prdata  = prdata_q;
    assign o_pc      = pc_q;
    assign o_busy    = busy;

    cx_alu u_alu (
        .i_op_valid   (executing),
        .i_op         (op_q),
        .i_accum      (accum_q),
        .i_fval       (fval),
        .i_literal    (lit_q),
        .i_carry      (c_q),
        .o_result     (alu_res),
        .o_carry      (alu_c),
        .o_half_carry (alu_hc),
        .o_zero       (alu_z),
        .o_upd_c      (upd_c),
        .o_upd_hc     (upd_hc),
        .o_upd_z      (upd_z),
        .o_file_op    (file_op)
    );

    // read data, captured in the setup phase
    always_comb begin
        prdata_d = prdata_q;
        if (i_psel && !i_penable) begin
            case (i_paddr)
                cx_pkg::OFF_CMD:    prdata_d = {8'h00, lit_q, 5'h00, fa_q, dest_q, op_q};
                cx_pkg::OFF_ACCUM:  prdata_d = {24'h000000, accum_q};
                cx_pkg::OFF_STATUS: prdata_d = {23'h000000, busy, 5'h00, z_q, hc_q, c_q};
                cx_pkg::OFF_PC:     prdata_d = {19'h00000, pc_q};
                cx_pkg::OFF_PUSH:   prdata_d = {29'h00000000, sp_q};
                cx_pkg::OFF_FADDR:  prdata_d = {25'h0000000, faddr_q};
                cx_pkg::OFF_FDATA:  prdata_d = {24'h000000, file_mem[faddr_q]};
                default:            prdata_d = 32'h00000000;
            endcase
        end
    end

    // sequencer, register writes and instruction execution
    always_comb begin
        state_d = state_q;
        op_d    = op_q;
        dest_d  = dest_q;
        fa_d    = fa_q;
        lit_d   = lit_q;
        accum_d = accum_q;
        c_d     = c_q;
        hc_d    = hc_q;
        z_d     = z_q;
        pc_d    = pc_q;
        sp_d    = sp_q;
        faddr_d = faddr_q;
        file_we = 1'b0;
        file_wa = fa_q;
        file_wd = alu_res;
        stk_we  = 1'b0;
        unique case (state_q)
            cx_pkg::st_idle: begin
                if (wr_fire) begin
                    case (i_paddr)
                        cx_pkg::OFF_CMD: begin
                            op_d    = cx_pkg::cx_op_t'(i_pwdata[cx_pkg::CMD_OP_LSB +:
                                                                cx_pkg::OP_W]);
                            dest_d  = i_pwdata[cx_pkg::CMD_DEST_BIT];
                            fa_d    = i_pwdata[cx_pkg::CMD_FA_LSB +: cx_pkg::FADDR_W];
                            lit_d   = i_pwdata[cx_pkg::CMD_LIT_LSB +: 8];
                            state_d = cx_pkg::st_exec;
                        end
                        cx_pkg::OFF_ACCUM: accum_d = i_pwdata[7:0];
                        cx_pkg::OFF_STATUS: begin
                            c_d  = i_pwdata[cx_pkg::STAT_C_BIT];
                            hc_d = i_pwdata[cx_pkg::STAT_HC_BIT];
                            z_d  = i_pwdata[cx_pkg::STAT_Z_BIT];
                        end
                        cx_pkg::OFF_PUSH: begin
                            stk_we = 1'b1;
                            sp_d   = sp_q + cx_pkg::SP_ONE;
                        end
                        cx_pkg::OFF_FADDR: faddr_d = i_pwdata[cx_pkg::FADDR_W-1:0];
                        cx_pkg::OFF_FDATA: begin
                            file_we = 1'b1;
                            file_wa = faddr_q;
                            file_wd = i_pwdata[7:0];
                        end
                        default: ;
                    endcase
                end
            end
            cx_pkg::st_exec: begin
                if (op_q == cx_pkg::op_return) begin
                    pc_d    = stack_top;           // pop into program counter [RQ1]
                    sp_d    = sp_dec;              // [RQ1]
                    state_d = cx_pkg::st_ret;      // second cycle, flags untouched [RQ1]
                end else begin
                    if (file_op && dest_q) begin
                        file_we = 1'b1;            // write back to the file register [RQ3]
                    end else begin
                        accum_d = alu_res;         // accumulator destination [RQ3]
                    end
                    if (upd_c) c_d = alu_c;        // [RQ2] [RQ4] [RQ5]
                    if (upd_hc) hc_d = alu_hc;     // [RQ9]
                    if (upd_z) z_d = alu_z;        // [RQ7] [RQ8] [RQ9]
                    state_d = cx_pkg::st_idle;
                end
            end
            cx_pkg::st_ret: state_d = cx_pkg::st_idle;
            default: state_d = cx_pkg::st_idle;
        endcase
    end

    // control and data registers
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_q  <= cx_pkg::st_idle;
            op_q     <= cx_pkg::op_none;
            dest_q   <= 1'b0;
            fa_q     <= '0;
            lit_q    <= 8'h00;
            accum_q  <= cx_pkg::ACCUM_RST;
            c_q      <= 1'b0;
            hc_q     <= 1'b0;
            z_q      <= 1'b0;
            pc_q     <= cx_pkg::PC_RST;
            sp_q     <= cx_pkg::SP_RST;
            faddr_q  <= '0;
            prdata_q <= 32'h00000000;
        end else begin
            state_q  <= state_d;
            op_q     <= op_d;
            dest_q   <= dest_d;
            fa_q     <= fa_d;
            lit_q    <= lit_d;
            accum_q  <= accum_d;
            c_q      <= c_d;
            hc_q     <= hc_d;
            z_q      <= z_d;
            pc_q     <= pc_d;
            sp_q     <= sp_d;
            faddr_q  <= faddr_d;
            prdata_q <= prdata_d;
        end
    end

    // file registers and return stack storage
    always_ff @(posedge i_core_clk) begin
        if (file_we) begin
            file_mem[file_wa] <= file_wd;
        end
        if (stk_we) begin
            stack_mem[sp_q] <= i_pwdata[cx_pkg::PC_W-1:0];
        end
    end

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_reset_n);

    sequence ret_start_s;
        executing && op_q == cx_pkg::op_return;
    endsequence
    sequence ret_tail_s;
        state_q == cx_pkg::st_ret ##1 state_q == cx_pkg::st_idle;
    endsequence

    ret_two_cycle_a: assert property (ret_start_s |=> ret_tail_s) // [RQ1]
        else $error("return did not take two cycles");
    ret_pc_load_a: assert property (ret_start_s |=> // [RQ1]
        pc_q == $past(stack_top) && sp_q == $past(sp_dec))
        else $error("return did not pop the stack into the pc");
    ret_flags_keep_a: assert property (ret_start_s |=> // [RQ1]
        $stable({c_q, hc_q, z_q, accum_q})[*2])
        else $error("return changed flags or accumulator");
    rotate_carry_a: assert property (executing && op_q == cx_pkg::rotate_right_carry_op // [RQ2]
        |=> c_q == $past(fval[0]) && $stable({hc_q, z_q}))
        else $error("rotate carry out wrong");
    rotate_value_a: assert property (executing && op_q == cx_pkg::rotate_right_carry_op // [RQ2]
        && !dest_q |=> accum_q == {$past(c_q), $past(fval[7:1])})
        else $error("rotate result wrong");
    dest_file_a: assert property (executing && file_op && dest_q // [RQ3]
        |-> file_we && file_wa == fa_q ##1 $stable(accum_q))
        else $error("file destination not honoured");
    lit_sub_a: assert property (executing && op_q == cx_pkg::literal_minus_accum_op // [RQ4]
        |=> accum_q == 8'($past(lit_q) - $past(accum_q)))
        else $error("literal subtract result wrong");
    sub_borrow_a: assert property (executing && op_q == cx_pkg::file_minus_accum_op // [RQ5]
        |=> c_q == ($past(fval) >= $past(accum_q))
            && hc_q == ($past(fval[3:0]) >= $past(accum_q[3:0])))
        else $error("subtract carry or half carry wrong");
    // a difference is zero exactly when both operands are equal
    sub_zero_a: assert property (executing && (op_q == cx_pkg::file_minus_accum_op // [RQ9]
        || op_q == cx_pkg::literal_minus_accum_op) |=> z_q == ($past(accum_q)
        == ($past(op_q) == cx_pkg::file_minus_accum_op ? $past(fval) : $past(lit_q))))
        else $error("subtract zero flag wrong");
    swap_value_a: assert property (executing && op_q == cx_pkg::nibble_exchange_op // [RQ6]
        |-> alu_res == {fval[3:0], fval[7:4]} ##1 $stable({c_q, hc_q, z_q}))
        else $error("nibble swap wrong or flags moved");
    lit_xor_a: assert property (executing && op_q == cx_pkg::literal_xor_op // [RQ7]
        |=> accum_q == ($past(accum_q) ^ $past(lit_q)) && $stable({c_q, hc_q}))
        else $error("literal xor wrong");
    file_xor_a: assert property (executing && op_q == cx_pkg::file_xor_op // [RQ8]
        |=> z_q == (($past(accum_q) ^ $past(fval)) == 8'h00) && $stable({c_q, hc_q}))
        else $error("file xor zero flag wrong");
endmodule
`default_nettype wire

// file: tb/tb.sv
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    // design ports and bench bookkeeping
    logic                        core_clk;
    logic                        reset_n;
    logic                        psel;
    logic                        penable;
    logic                        pwrite;
    logic [cx_pkg::ADDR_W-1:0]   paddr;
    logic [cx_pkg::DATA_W-1:0]   pwdata;
    logic [cx_pkg::DATA_W-1:0]   prdata;
    logic                        pready;
    logic                        pslverr;
    logic [cx_pkg::PC_W-1:0]     pc;
    logic                        busy;
    logic [cx_pkg::DATA_W-1:0]   rd;
    logic                        rerr;
    int                          mismatches;
    int                          num_checks;
    int                          stall;
    int                          cyc;
    logic                        chain;
    logic                        linked;

    cx_exec cx_exec_i (
        .i_core_clk (core_clk),
        .i_reset_n  (reset_n),
        .i_psel     (psel),
        .i_penable  (penable),
        .i_pwrite   (pwrite),
        .i_paddr    (paddr),
        .i_pwdata   (pwdata),
        .o_prdata   (prdata),
        .o_pready   (pready),
        .o_pslverr  (pslverr),
        .o_pc       (pc),
        .o_busy     (busy)
    );

    // 40 mhz core clock
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    // compare one value, count it, report a mismatch
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // print the counts and the verdict, then stop
    task automatic summarize();
        $display("checks=%0d mismatches=%0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // one apb transfer; waits for pready, counts the stalled cycles
    // with chain set psel stays high and the next setup follows at once
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        if (!linked) begin
            @(posedge core_clk);
        end
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        stall = 0;
        @(posedge core_clk);
        while (pready !== 1'b1 && stall < 20) begin
            stall++;
            @(posedge core_clk);
        end
        if (stall == 20) begin
            check(32'h0, 32'h1);
        end
        rd   = prdata;
        rerr = pslverr;
        penable <= 1'b0;
        if (!chain) begin
            psel <= 1'b0;
        end
        linked = chain;
    endtask

    // command word: literal, file address, destination, operation
    function automatic logic [31:0] mk(cx_pkg::cx_op_t op, logic dst, logic [6:0] fa,
                                       logic [7:0] lit);
        return {8'h00, lit, 5'h00, fa, dst, op};
    endfunction

    // issue a command and count the cycles it keeps busy high
    task automatic exec(input logic [31:0] c);
        apb(1'b1, cx_pkg::OFF_CMD, c);
        cyc = 0;
        @(posedge core_clk);
        while (busy === 1'b1 && cyc < 8) begin
            cyc++;
            @(posedge core_clk);
        end
    endtask

    // preload state, run one instruction, compare accum, status and file register
    task automatic run(cx_pkg::cx_op_t op, logic dst, logic [6:0] fa, logic [7:0] lit,
                       logic [7:0] a0, logic [7:0] s0, logic [7:0] f0,
                       logic [7:0] ea, logic [7:0] es, logic [7:0] ef);
        apb(1'b1, cx_pkg::OFF_ACCUM, {24'h0, a0});
        apb(1'b1, cx_pkg::OFF_STATUS, {24'h0, s0});
        apb(1'b1, cx_pkg::OFF_FADDR, {25'h0, fa});
        apb(1'b1, cx_pkg::OFF_FDATA, {24'h0, f0});
        exec(mk(op, dst, fa, lit));
        check(32'(cyc), (op == cx_pkg::op_return) ? cx_pkg::RET_CYCLES : 32'h1);
        apb(1'b0, cx_pkg::OFF_ACCUM, 32'h0);
        check(rd, {24'h0, ea});
        apb(1'b0, cx_pkg::OFF_STATUS, 32'h0);
        check(rd, {24'h0, es});
        apb(1'b0, cx_pkg::OFF_FDATA, 32'h0);
        check(rd, {24'h0, ef});
    endtask

    // watchdog well beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge core_clk);
        mismatches++;
        summarize();
    end

    // main sequence
    initial begin
        reset_n = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
        chain   = 1'b0;
        linked  = 1'b0;
        repeat (12) @(posedge core_clk);
        reset_n <= 1'b1;
        check({19'h0, pc}, 32'h0);
        apb(1'b0, cx_pkg::OFF_STATUS, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 8'h1c, 32'h0);
        check({31'h0, rerr}, 32'h1);
        check(rd, 32'h0);
        $display("test reset_and_unmapped done");

        // rotate right through carry, both destinations, address bounds
        run(cx_pkg::rotate_right_carry_op, 1'b1, 7'h00, 8'h00,
            8'h11, 8'h06, 8'h81, 8'h11, 8'h07, 8'h40);
        run(cx_pkg::rotate_right_carry_op, 1'b0, 7'h7f, 8'h00,
            8'h11, 8'h01, 8'h40, 8'ha0, 8'h00, 8'h40);
        $display("test rotate done");

        // literal minus accum: borrow, equal, top literal
        run(cx_pkg::literal_minus_accum_op, 1'b0, 7'h05, 8'h03,
            8'h05, 8'h07, 8'h22, 8'hfe, 8'h00, 8'h22);
        run(cx_pkg::literal_minus_accum_op, 1'b0, 7'h05, 8'h05,
            8'h05, 8'h00, 8'h22, 8'h00, 8'h07, 8'h22);
        run(cx_pkg::literal_minus_accum_op, 1'b1, 7'h05, 8'hff,
            8'h00, 8'h00, 8'h99, 8'hff, 8'h03, 8'h99);
        $display("test literal_subtract done");

        // file minus accum to file and to accum
        run(cx_pkg::file_minus_accum_op, 1'b1, 7'h10, 8'h00,
            8'h01, 8'h06, 8'h10, 8'h01, 8'h01, 8'h0f);
        run(cx_pkg::file_minus_accum_op, 1'b0, 7'h7f, 8'h00,
            8'h00, 8'h00, 8'h00, 8'h00, 8'h07, 8'h00);
        $display("test file_subtract done");

        // nibble exchange keeps every flag, even on a zero result
        run(cx_pkg::nibble_exchange_op, 1'b1, 7'h21, 8'h00,
            8'h33, 8'h05, 8'ha5, 8'h33, 8'h05, 8'h5a);
        run(cx_pkg::nibble_exchange_op, 1'b0, 7'h21, 8'h00,
            8'h33, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
        $display("test nibble_exchange done");

        // exclusive or touches zero only
        run(cx_pkg::literal_xor_op, 1'b0, 7'h30, 8'h3c,
            8'h3c, 8'h03, 8'h44, 8'h00, 8'h07, 8'h44);
        run(cx_pkg::literal_xor_op, 1'b0, 7'h30, 8'hff,
            8'h0f, 8'h07, 8'h44, 8'hf0, 8'h03, 8'h44);
        run(cx_pkg::file_xor_op, 1'b1, 7'h40, 8'h00,
            8'haa, 8'h04, 8'h55, 8'haa, 8'h00, 8'hff);
        run(cx_pkg::file_xor_op, 1'b0, 7'h40, 8'h00,
            8'h55, 8'h03, 8'h55, 8'h00, 8'h07, 8'h55);
        $display("test xor done");

        // return pops the last push, keeps flags, lasts two cycles
        apb(1'b1, cx_pkg::OFF_PUSH, 32'h0123);
        apb(1'b1, cx_pkg::OFF_PUSH, 32'h1abc);
        apb(1'b0, cx_pkg::OFF_PUSH, 32'h0);
        check(rd, 32'h2);
        run(cx_pkg::op_return, 1'b0, 7'h05, 8'h00,
            8'h12, 8'h05, 8'h34, 8'h12, 8'h05, 8'h34);
        check({19'h0, pc}, 32'h1abc);
        // a write set up right behind a return has to stall until it ends
        chain = 1'b1;
        apb(1'b1, cx_pkg::OFF_CMD, mk(cx_pkg::op_return, 1'b0, 7'h00, 8'h00));
        chain = 1'b0;
        apb(1'b1, cx_pkg::OFF_ACCUM, 32'h77);
        check({31'h0, stall != 0}, 32'h1);
        check({19'h0, pc}, 32'h0123);
        apb(1'b0, cx_pkg::OFF_ACCUM, 32'h0);
        check(rd, 32'h77);
        check({31'h0, rerr}, 32'h0);
        apb(1'b0, cx_pkg::OFF_PUSH, 32'h0);
        check(rd, 32'h0);
        $display("test return done");

        // an unmapped write changes nothing
        apb(1'b1, 8'h1c, 32'hff);
        check({31'h0, rerr}, 32'h1);
        apb(1'b0, cx_pkg::OFF_ACCUM, 32'h0);
        check(rd, 32'h77);
        $display("test unmapped_write done");
        summarize();
    end
endmodule
`default_nettype wire
